// >>> inc/rsv_pkg.sv
// constants shared by the receive symbol checker
`default_nettype none

package rsv_pkg;

    // ------------------------------------------------------------
    // width modes taken from the mode pins
    // ------------------------------------------------------------
    localparam logic [1:0] RSV_MODE_8 = 2'h0;
    localparam logic [1:0] RSV_MODE_9 = 2'h1;
    localparam logic [1:0] RSV_MODE_10 = 2'h2;

    // ------------------------------------------------------------
    // framing: coded bits per byte and window size
    // ------------------------------------------------------------
    localparam int RSV_WIN_W = 12;
    localparam int RSV_CNT_W = 4;
    localparam logic [3:0] RSV_BYTE_LEN_5B = 4'hA;
    localparam logic [3:0] RSV_BYTE_LEN_6B = 4'hC;
    localparam logic [3:0] RSV_CNT_RST = 4'h0;

    // ------------------------------------------------------------
    // sync patterns after nrzi decoding, first bit leftmost
    // ------------------------------------------------------------
    localparam logic [9:0] RSV_SYNC_5B = 10'h311;
    localparam logic [11:0] RSV_SYNC_6B = 12'hC23;

    // ------------------------------------------------------------
    // 4b/5b control symbols and the command code each stands for
    // ------------------------------------------------------------
    localparam logic [4:0] RSV_SYM_QUIET = 5'h00;
    localparam logic [4:0] RSV_SYM_IDLE = 5'h1F;
    localparam logic [4:0] RSV_SYM_HALT = 5'h04;
    localparam logic [4:0] RSV_SYM_TERM = 5'h0D;
    localparam logic [4:0] RSV_SYM_RESET = 5'h07;
    localparam logic [4:0] RSV_SYM_SET = 5'h19;
    localparam logic [3:0] RSV_CMD_QUIET = 4'hF;
    localparam logic [3:0] RSV_CMD_IDLE = 4'hE;
    localparam logic [3:0] RSV_CMD_HALT = 4'hD;
    localparam logic [3:0] RSV_CMD_TERM = 4'hC;
    localparam logic [3:0] RSV_CMD_RESET = 4'hB;
    localparam logic [3:0] RSV_CMD_SET = 4'hA;

    // ------------------------------------------------------------
    // command output masks per width mode, violation command value
    // ------------------------------------------------------------
    localparam logic [3:0] RSV_CMD_MASK_8 = 4'hF;
    localparam logic [3:0] RSV_CMD_MASK_9 = 4'h7;
    localparam logic [3:0] RSV_CMD_MASK_10 = 4'h3;
    localparam logic [3:0] RSV_CMD_ALL_ONES = 4'hF;

    // ------------------------------------------------------------
    // 5b/6b classes: ones count of a command symbol
    // ------------------------------------------------------------
    localparam logic [2:0] RSV_6B_CMD_ONES = 3'h2;

endpackage : rsv_pkg

`default_nettype wire

// >>> verilog/rsv_sym_dec.sv
// combinational byte decoder: symbols to data, command and violation
`default_nettype none

module rsv_sym_dec
    import rsv_pkg::*;
(
    input wire logic [1:0] i_mode,
    input wire logic [11:0] i_win,
    output logic o_is_cmd,
    output logic [9:0] o_data,
    output logic [3:0] o_cmd,
    output logic o_viol
);

    // ------------------------------------------------------------
    // symbol lookups, returning {valid, control, value}
    // ------------------------------------------------------------
    function automatic logic [5:0] dec5(input logic [4:0] s);
        logic [5:0] r;
        r = 6'h00;
        case (s)
            5'h1E: r = {2'b10, 4'h0};
            5'h09: r = {2'b10, 4'h1};
            5'h14: r = {2'b10, 4'h2};
            5'h15: r = {2'b10, 4'h3};
            5'h0A: r = {2'b10, 4'h4};
            5'h0B: r = {2'b10, 4'h5};
            5'h0E: r = {2'b10, 4'h6};
            5'h0F: r = {2'b10, 4'h7};
            5'h12: r = {2'b10, 4'h8};
            5'h13: r = {2'b10, 4'h9};
            5'h16: r = {2'b10, 4'hA};
            5'h17: r = {2'b10, 4'hB};
            5'h1A: r = {2'b10, 4'hC};
            5'h1B: r = {2'b10, 4'hD};
            5'h1C: r = {2'b10, 4'hE};
            5'h1D: r = {2'b10, 4'hF};
            RSV_SYM_QUIET: r = {2'b11, RSV_CMD_QUIET};
            RSV_SYM_IDLE: r = {2'b11, RSV_CMD_IDLE};
            RSV_SYM_HALT: r = {2'b11, RSV_CMD_HALT};
            RSV_SYM_TERM: r = {2'b11, RSV_CMD_TERM};
            RSV_SYM_RESET: r = {2'b11, RSV_CMD_RESET};
            RSV_SYM_SET: r = {2'b11, RSV_CMD_SET};
            default: r = 6'h00;
        endcase
        return r;
    endfunction

    // 6b data: odd ones count; command: exactly two ones
    function automatic logic [6:0] dec6(input logic [5:0] s);
        logic [2:0] ones;
        logic [6:0] r;
        ones = 3'(s[0]) + 3'(s[1]) + 3'(s[2]) + 3'(s[3]) + 3'(s[4]) + 3'(s[5]);
        r = 7'h00;
        if (ones[0]) begin
            r = {2'b10, s[4:0]};
        end else if (ones == RSV_6B_CMD_ONES) begin
            r = {2'b11, s[4:0]};
        end
        return r;
    endfunction

    // ------------------------------------------------------------
    // byte assembly from the two symbols of the window
    // ------------------------------------------------------------
    always_comb begin
        logic [5:0] h5;
        logic [5:0] l5;
        logic [6:0] h6;
        logic [6:0] l6;
        logic both_data;
        logic both_cmd;
        logic [3:0] mask;
        h5 = dec5(i_win[9:5]);
        l5 = dec5(i_win[4:0]);
        h6 = dec6(i_win[11:6]);
        l6 = dec6(i_win[5:0]);
        o_data = 10'h000;
        o_cmd = 4'h0;
        mask = RSV_CMD_MASK_8;
        both_data = 1'b0;
        both_cmd = 1'b0;
        if (i_mode == RSV_MODE_8) begin
            both_data = h5[5:4] == 2'b10 && l5[5:4] == 2'b10;
            both_cmd = h5[5:4] == 2'b11 && l5[5:4] == 2'b11 && h5[3:0] == l5[3:0];
            o_data = {2'b00, h5[3:0], l5[3:0]};
            o_cmd = h5[3:0];
        end else begin
            mask = (i_mode == RSV_MODE_9) ? RSV_CMD_MASK_9 : RSV_CMD_MASK_10;
            both_data = h6[6:5] == 2'b10 && l6[6:5] == 2'b10;
            if (i_mode == RSV_MODE_9 && h6[4]) begin
                both_data = 1'b0;
            end
            both_cmd = h6[6:5] == 2'b11 && l6[6:5] == 2'b11 && h6[4:0] == l6[4:0];
            o_data = {h6[4:0], l6[4:0]} & ((i_mode == RSV_MODE_9) ? 10'h1FF : 10'h3FF);
            o_cmd = h6[3:0];
        end
        // two data symbols (top value bit clear in mode 9) or two equal command symbols pass as decoded, anything else flags
        o_viol = !(both_data || both_cmd);
        o_is_cmd = !both_data;
        if (o_viol) begin
            o_cmd = RSV_CMD_ALL_ONES;
        end
        o_cmd = o_cmd & mask;
    end

endmodule // rsv_sym_dec

`default_nettype wire

// >>> verilog/rsv_rx_check.sv
// receive framing, sync alignment and symbol violation checking
`default_nettype none

module rsv_rx_check
    import rsv_pkg::*;
(
    input wire logic i_sys_clk,
    input wire logic i_reset_n,
    input wire logic i_ser_line,
    input wire logic [1:0] i_mode,
    output logic [9:0] o_data,
    output logic o_data_byte_strobe,
    output logic [3:0] o_cmd,
    output logic o_command_byte_strobe,
    output logic o_symbol_violation_flag,
    output logic o_sync_seen
);

    // ------------------------------------------------------------
    // framing state
    // ------------------------------------------------------------
    typedef enum logic [1:0] {
        RSV_ST_FILL = 2'b01,
        RSV_ST_RUN = 2'b10
    } rsv_state_t;

    // coded bits that make one byte in the given mode
    function automatic logic [3:0] byte_len(input logic [1:0] mode);
        return (mode == RSV_MODE_8) ? RSV_BYTE_LEN_5B : RSV_BYTE_LEN_6B;
    endfunction

    // sync compare over the window for the given mode
    function automatic logic sync_hit(input logic [1:0] mode, input logic [11:0] win);
        if (mode == RSV_MODE_8) begin
            return win[9:0] == RSV_SYNC_5B;
        end
        return win == RSV_SYNC_6B;
    endfunction

    rsv_state_t state_q;
    rsv_state_t state_d;
    logic line_q;
    logic line_d;
    logic [11:0] win_q;
    logic [11:0] win_d;
    logic [3:0] cnt_q;
    logic [3:0] cnt_d;
    logic [9:0] data_q;
    logic [9:0] data_d;
    logic [3:0] cmd_q;
    logic [3:0] cmd_d;
    logic dstb_q;
    logic dstb_d;
    logic cstb_q;
    logic cstb_d;
    logic viol_q;
    logic viol_d;
    logic sync_q;
    logic sync_d;
    logic dec_is_cmd;
    logic [9:0] dec_data;
    logic [3:0] dec_cmd;
    logic dec_viol;

    // ------------------------------------------------------------
    // symbol decoder on the window that includes the newest bit
    // ------------------------------------------------------------
    rsv_sym_dec u_dec (
        .i_mode(i_mode),
        .i_win(win_d),
        .o_is_cmd(dec_is_cmd),
        .o_data(dec_data),
        .o_cmd(dec_cmd),
        .o_viol(dec_viol)
    );

    // ------------------------------------------------------------
    // next-state: nrzi decode, shift, count, sync and byte output
    // ------------------------------------------------------------
    always_comb begin
        logic [3:0] last;
        logic hit;
        logic byte_done;
        last = byte_len(i_mode) - 4'h1;
        // transition on the line is a one, steady line a zero
        line_d = i_ser_line;
        win_d = {win_q[10:0], i_ser_line ^ line_q};
        hit = sync_hit(i_mode, win_d);
        state_d = state_q;
        cnt_d = cnt_q + 4'h1;
        sync_d = sync_q;
        byte_done = 1'b0;
        data_d = data_q;
        cmd_d = cmd_q;
        dstb_d = 1'b0;
        cstb_d = 1'b0;
        viol_d = 1'b0;
        case (state_q)
            RSV_ST_FILL: begin
                // window not yet full of line bits since reset
                if (cnt_q >= last || hit) begin
                    state_d = RSV_ST_RUN;
                    cnt_d = RSV_CNT_RST;
                end
                if (hit) begin
                    sync_d = 1'b1;
                end
            end
            RSV_ST_RUN: begin
                if (hit) begin
                    // any match, false or genuine, sets the boundary here
                    cnt_d = RSV_CNT_RST;
                    sync_d = 1'b1;
                end else if (cnt_q >= last) begin
                    cnt_d = RSV_CNT_RST;
                    byte_done = 1'b1;
                end
            end
            default: begin
                state_d = RSV_ST_FILL;
                cnt_d = RSV_CNT_RST;
            end
        endcase
        // strobes, violation flag and the data or command pins update together on the byte edge
        if (byte_done) begin
            // data and command pins each hold until a byte of their own kind
            if (dec_is_cmd) begin
                cmd_d = dec_cmd;
            end else begin
                data_d = dec_data;
            end
            dstb_d = !dec_is_cmd;
            cstb_d = dec_is_cmd;
            viol_d = dec_viol;
        end
    end

    // ------------------------------------------------------------
    // state registers
    // ------------------------------------------------------------
    always_ff @(posedge i_sys_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            state_q <= RSV_ST_FILL;
            line_q <= 1'b0;
            win_q <= 12'h000;
            cnt_q <= RSV_CNT_RST;
            data_q <= 10'h000;
            cmd_q <= 4'h0;
            dstb_q <= 1'b0;
            cstb_q <= 1'b0;
            viol_q <= 1'b0;
            sync_q <= 1'b0;
        end else begin
            state_q <= state_d;
            line_q <= line_d;
            win_q <= win_d;
            cnt_q <= cnt_d;
            data_q <= data_d;
            cmd_q <= cmd_d;
            dstb_q <= dstb_d;
            cstb_q <= cstb_d;
            viol_q <= viol_d;
            sync_q <= sync_d;
        end
    end

    // ------------------------------------------------------------
    // outputs straight from flip-flops
    // ------------------------------------------------------------
    assign o_data = data_q;
    assign o_data_byte_strobe = dstb_q;
    assign o_cmd = cmd_q;
    assign o_command_byte_strobe = cstb_q;
    assign o_symbol_violation_flag = viol_q;
    assign o_sync_seen = sync_q;

endmodule // rsv_rx_check

`default_nettype wire

// >>> verification/rsv_tx_model.sv
// serial transmitter model driving the coded line
`default_nettype none
module rsv_tx_model (
    input wire logic i_sys_clk,
    input wire logic i_reset_n,
    output logic o_line
);
    timeunit 1ns;
    timeprecision 100ps;
    bit q[$];
    // nrzi: a coded one toggles the line, an empty queue leaves it still
    always @(posedge i_sys_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            o_line <= 1'b0;
        end else if (q.size() > 0) begin
            o_line <= o_line ^ q.pop_front();
        end
    end
endmodule // rsv_tx_model
`default_nettype wire

// >>> verification/rsv_rx_check_checker.sv
// assertion checker for the receive symbol checker
`default_nettype none
module rsv_rx_check_checker
    import rsv_pkg::*;
(
    input wire logic i_sys_clk,
    input wire logic i_reset_n,
    input wire logic i_ser_line,
    input wire logic [1:0] i_mode,
    input wire logic [9:0] o_data,
    input wire logic o_data_byte_strobe,
    input wire logic [3:0] o_cmd,
    input wire logic o_command_byte_strobe,
    input wire logic o_symbol_violation_flag,
    input wire logic o_sync_seen
);
    timeunit 1ns;
    timeprecision 100ps;
    logic line_q, line_d, stb, m8;
    logic [5:0] quiet_q, quiet_d;
    logic [3:0] mask;
    default clocking @(posedge i_sys_clk); endclocking
    default disable iff (!i_reset_n);
    // ------------------------------------------------------------
    // quiet line counter: cycles since the last transition
    // ------------------------------------------------------------
    always_comb begin
        line_d = i_ser_line;
        quiet_d = (i_ser_line != line_q) ? 6'h00 : quiet_q + {5'h00, quiet_q != 6'h3F};
    end
    always_ff @(posedge i_sys_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            line_q <= 1'b0;
            quiet_q <= 6'h00;
        end else begin
            line_q <= line_d;
            quiet_q <= quiet_d;
        end
    end
    assign stb = o_data_byte_strobe | o_command_byte_strobe;
    assign m8 = (i_mode == RSV_MODE_8);
    assign mask = m8 ? 4'hF : (i_mode == RSV_MODE_9) ? 4'h7 : 4'h3;
    chk_viol_cmd_ones: assert property (
        o_symbol_violation_flag |-> o_command_byte_strobe && o_cmd == mask)
        else $error("violation without all-ones command");
    chk_strobe_gap: assert property (stb |=> (!stb) [*8])
        else $error("strobes too close");
    chk_data_hold: assert property ($changed(o_data) |-> o_data_byte_strobe)
        else $error("data moved without strobe");
    chk_cmd_hold: assert property ($changed(o_cmd) |-> o_command_byte_strobe)
        else $error("command moved without strobe");
    chk_quiet_narrow: assert property (
        m8 && quiet_q > 6'd21 && stb |-> o_command_byte_strobe && o_cmd == 4'hF
        && !o_symbol_violation_flag) else $error("quiet line not command F");
    chk_quiet_rate: assert property (
        m8 && quiet_q > 6'd21 && stb |-> ##10 (stb || quiet_q < 6'd10))
        else $error("quiet line strobe not every byte");
    chk_quiet_wide: assert property (
        !m8 && quiet_q > 6'd25 && stb |-> o_command_byte_strobe && o_symbol_violation_flag)
        else $error("quiet wide line without violation");
    chk_sync_sticky: assert property (o_sync_seen |=> o_sync_seen)
        else $error("sync seen dropped");
    cov_quiet: cover property (m8 && quiet_q > 6'd21 && o_command_byte_strobe);
    cov_viol: cover property (!m8 && o_symbol_violation_flag);
    cov_sync: cover property ($rose(o_sync_seen));
endmodule // rsv_rx_check_checker
bind rsv_rx_check rsv_rx_check_checker u_chk (.i_sys_clk(i_sys_clk), .i_reset_n(i_reset_n),
    .i_ser_line(i_ser_line), .i_mode(i_mode), .o_data(o_data),
    .o_data_byte_strobe(o_data_byte_strobe), .o_cmd(o_cmd),
    .o_command_byte_strobe(o_command_byte_strobe),
    .o_symbol_violation_flag(o_symbol_violation_flag), .o_sync_seen(o_sync_seen));
`default_nettype wire

// >>> verification/rsv_rx_check_tb.sv
// self-checking bench for the receive symbol checker
`default_nettype none
module rsv_rx_check_tb
    import rsv_pkg::*;
;
    timeunit 1ns;
    timeprecision 100ps;
    logic i_sys_clk, i_reset_n, ser, dstb, cstb, viol, sync_seen;
    logic [1:0] mode;
    logic [9:0] o_data;
    logic [3:0] o_cmd;
    logic [31:0] seed = 32'd73524;
    logic [11:0] win;
    logic [11:0] expq[$];
    logic [4:0] t5[16] = '{5'h1E, 5'h09, 5'h14, 5'h15, 5'h0A, 5'h0B, 5'h0E, 5'h0F,
                           5'h12, 5'h13, 5'h16, 5'h17, 5'h1A, 5'h1B, 5'h1C, 5'h1D};
    logic [4:0] c5[6] = '{5'h00, 5'h1F, 5'h04, 5'h0D, 5'h07, 5'h19};
    int failures, num_checks, cnt, len;
    bit fill;
    rsv_rx_check u_rsv_rx_check (.i_sys_clk(i_sys_clk), .i_reset_n(i_reset_n),
        .i_ser_line(ser), .i_mode(mode), .o_data(o_data), .o_data_byte_strobe(dstb),
        .o_cmd(o_cmd), .o_command_byte_strobe(cstb), .o_symbol_violation_flag(viol),
        .o_sync_seen(sync_seen));
    rsv_tx_model u_rsv_tx_model (.i_sys_clk(i_sys_clk), .i_reset_n(i_reset_n), .o_line(ser));
    // ------------------------------------------------------------
    // reference model of framing and decoding
    // ------------------------------------------------------------
    function automatic logic [31:0] xs();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction
    function automatic int sym(logic [4:0] s);
        for (int i = 0; i < 16; i++)
            if (t5[i] == s) return i;
        foreach (c5[i])
            if (c5[i] == s) return 31 - i;
        return -1;
    endfunction
    // result word: command flag, violation, value
    function automatic logic [11:0] dec(logic [11:0] w);
        int h, l;
        h = sym(w[9:5]);
        l = sym(w[4:0]);
        if (mode == RSV_MODE_8) begin
            if (h >= 0 && h < 16 && l >= 0 && l < 16) return {4'h0, h[3:0], l[3:0]};
            if (h >= 16 && h == l) return {8'h80, h[3:0]};
            return 12'hC0F;
        end
        if ($countones(w[11:6]) == 2 && w[11:6] == w[5:0])
            return {2'b10, 6'h00, w[3:0] & ((mode == RSV_MODE_9) ? 4'h7 : 4'h3)};
        if (^w[11:6] && ^w[5:0] && !(mode == RSV_MODE_9 && w[10])) return {2'b00, w[10:6], w[4:0]};
        return (mode == RSV_MODE_9) ? 12'hC07 : 12'hC03;
    endfunction
    task automatic put(bit b);
        win = {win[10:0], b};
        u_rsv_tx_model.q.push_back(b);
        if (mode == RSV_MODE_8 ? win[9:0] == RSV_SYNC_5B : win == RSV_SYNC_6B) begin
            cnt = 0;
            fill = 0;
        end else if (++cnt == len) begin
            cnt = 0;
            if (!fill) expq.push_back(dec(win));
            fill = 0;
        end
    endtask
    task automatic send(logic [11:0] v, int n);
        for (int i = n - 1; i >= 0; i--)
            put(v[i]);
    endtask
    task automatic chk(logic [11:0] e, logic [11:0] a);
        num_checks++;
        if (a !== e) begin
            failures++;
            $display("[FAIL] t=%0t exp=%h act=%h", $time, e, a);
        end
    endtask
    task automatic rst(logic [1:0] m);
        i_reset_n <= 1'b0;
        mode <= m;
        repeat (2) @(posedge i_sys_clk);
        i_reset_n <= 1'b1;
        win = '0;
        // the still line at the release edge is taken as one coded zero
        cnt = 1;
        fill = 1;
        len = (m == RSV_MODE_8) ? 10 : 12;
    endtask
    task automatic drain();
        for (int i = 0; i < 4000 && u_rsv_tx_model.q.size() > 0; i++)
            @(posedge i_sys_clk);
        repeat (4) @(posedge i_sys_clk);
        chk(12'h000, 12'(expq.size()));
        chk(12'h001, {11'h000, sync_seen});
    endtask
    task automatic end_of_test();
        $display("checks %0d failures %0d", num_checks, failures);
        if (failures == 0 && num_checks > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask
    // every strobed byte is compared; flagged bytes count as invalid
    always @(negedge i_sys_clk) begin
        if (i_reset_n && (dstb || cstb)) begin
            if (expq.size() == 0) chk(12'hFFF, 12'h000);
            else chk(expq.pop_front(), {cstb, viol, cstb ? {6'h00, o_cmd} : o_data});
        end
    end
    initial begin
        i_sys_clk = 1'b0;
        forever #2 i_sys_clk = ~i_sys_clk;
    end
    initial begin
        repeat (20000) @(posedge i_sys_clk);
        failures++;
        end_of_test();
    end
    initial begin
        failures = 0;
        num_checks = 0;
        rst(RSV_MODE_8);
        send(RSV_SYNC_5B, 10);
        send({2'b00, t5[11], t5[2]}, 10);
        send({2'b00, t5[2], t5[2]}, 10);
        repeat (6) send({2'b00, t5[xs() & 15], t5[seed[7:4]]}, 10);
        send(12'h021, 10);
        foreach (c5[i]) send({2'b00, c5[i], c5[i]}, 10);
        send({2'b00, t5[5], c5[1]}, 10);
        send(12'h005, 3);
        send(RSV_SYNC_5B, 10);
        repeat (4) send({2'b00, t5[xs() & 15], t5[seed[7:4]]}, 10);
        repeat (4) send(12'h000, 10);
        drain();
        for (int m = 1; m < 3; m++) begin
            rst(2'(m));
            send(RSV_SYNC_6B, 12);
            repeat (8) begin
                void'(xs());
                send({~^seed[9:5], seed[9] && m == 2, seed[8:5], ~^seed[4:0], seed[4:0]}, 12);
            end
            send(12'h0C3, 12);
            send(12'h005, 5);
            send(RSV_SYNC_6B, 12);
            repeat (4) send(12'h000, 12);
            drain();
        end
        end_of_test();
    end
endmodule // rsv_rx_check_tb
`default_nettype wire
